/* File: design/cable_discover_identity_responder.sv */
// cable plug responder that frames the discover identity reply
//
// Overview of operation
// - request and reply both carry the PD standard id in the SVID field
// - ack carries id header, cert stat, product, then optional cable object
// - no data objects beyond header, cert, product and cable are ever sent
// - nak and busy replies report one object and carry no VDOs
// - id header bit 31 flags USB host capability
// - id header bit 30 flags USB device capability
// - product type is undefined, passive or active; reserved codes refused
// - id header bit 26 flags modal operation support
// - id header bits 25..16 forced zero; low half is the vendor id
// - cert stat object carries the 32-bit test id unchanged
// - product object holds product id high and bcdDevice low
// - cable object appended whenever product type is a cable
// - cable bits 31..24 carry hardware and firmware versions freely
// - cable object version avoids reserved codes; bit 20 forced zero
// - far connector code and plug/receptacle bit; receptacle illegal with c or captive
// - latency code must lie in 1..10
// - termination code passes unchanged in bits 12..11
// - bits 10..7 report superspeed lane directionality
// - vbus current code 11b is refused
// - vbus-through bit must agree with the current code
// - bit 3 reports a double-prime controller in the other plug
// - superspeed code above 010b refused
// - only prime start-of-packet requests are answered
// - command code 1 marks discover identity in request and reply
// - reply command type is ack 01b, nak 10b or busy 11b
//
// The address-and-strobe port and the placing of the registers were chosen for this implementation.
`timescale 1ns/1ns
`default_nettype none
`include "cable_id_cfg.svh"
module cable_discover_identity_responder
    import cable_id_pkg::*;
(
    // clock and reset
    input wire logic clk,
    input wire logic rstn,
    // received structured header
    input wire rx_req_t rx,
    // reply word stream
    input wire logic tx_ready,
    output tx_word_t tx,
    output logic resp_active,
    // register port
    input wire bus_req_t bus,
    output logic [31:0] bus_rdata
);
    logic rst_meta_r;
    logic rst_sync_r;
    core_t s_r;
    core_t s_nxt;

    logic disc_req;
    logic img_sel;
    logic img_wr;
    logic [1:0] img_idx;
    logic chk_legal;
    logic [31:0] chk_clean;
    logic [31:0] mem_a_q;
    logic [31:0] mem_b_q;
    logic mem_a_en;
    logic mem_b_en;
    logic is_cable;
    logic img_ok;
    logic [31:0] stat_word;
    logic [31:0] last_word;

    // reset release is retimed so the state leaves reset on a clean edge
    always_ff @(posedge clk or negedge rstn) begin
        if (!rstn) begin
            rst_meta_r <= 1'b0;
            rst_sync_r <= 1'b0;
        end else begin
            rst_meta_r <= 1'b1;
            rst_sync_r <= rst_meta_r;
        end
    end

    assign img_idx = bus.addr[3:2];
    assign img_sel = (bus.addr[7:4] == 4'h0) && (bus.addr[1:0] == 2'b00);
    // image is frozen while a reply is on the wire; a write in the request cycle still lands, so kind and count follow the old image and the words the new
    assign img_wr = bus.wr && img_sel && (s_r.st == TX_IDLE);
    assign mem_a_en = (s_r.st == TX_FETCH);
    assign mem_b_en = bus.rd && img_sel;

    vdo_field_check u_chk (
        .idx(img_idx),
        .word(bus.wdata),
        .legal(chk_legal),
        .clean(chk_clean)
    );

    id_image_mem #(
        .AW(2),
        .DW(32)
    ) u_mem (
        .clk(clk),
        .rst_n(rst_sync_r),
        .wr_en(img_wr),
        .wr_addr(img_idx),
        .wr_data(chk_clean),
        .a_en(mem_a_en),
        .a_addr(s_r.idx),
        .a_q(mem_a_q),
        .b_en(mem_b_en),
        .b_addr(img_idx),
        .b_q(mem_b_q)
    );

    assign disc_req = rx.valid && (rx.sop == SOP_PRIME) &&
                      (rx.hdr[`CID_SVID_HI:`CID_SVID_LO] == `CID_PD_SID) &&
                      rx.hdr[`CID_VDM_TYPE_BIT] &&
                      (rx.hdr[`CID_CT_HI:`CID_CT_LO] == CT_REQ) &&
                      (rx.hdr[`CID_CMD_HI:`CID_CMD_LO] == `CID_CMD_DISC_ID);

    assign is_cable = (s_r.ptype == `CID_PT_PASSIVE) || (s_r.ptype == `CID_PT_ACTIVE);
    // a header, cert or product word that was never written, or was refused, blocks the ack; the cable word does so only for cable types
    assign img_ok = (&s_r.legal[2:0]) && (!is_cable || s_r.legal[3]);

    assign stat_word = {s_r.drop_cnt, s_r.sent_cnt, 5'h00, s_r.ptype,
                        s_r.legal, 2'b00, s_r.err, resp_active};
    assign last_word = {27'h0000000, s_r.last_cnt, s_r.last_kind};

    always_comb begin
        s_nxt = s_r;
        s_nxt.rd_q = 1'b0;
        s_nxt.rd_mem = 1'b0;

        // register writes
        if (img_wr) begin
            s_nxt.legal[img_idx] = chk_legal;
            if (!chk_legal) begin
                s_nxt.err = 1'b1;
            end
            if (img_idx == `CID_IDX_HDR) begin
                s_nxt.ptype = bus.wdata[`CID_IDH_PT_HI:`CID_IDH_PT_LO];
            end
        end else if (bus.wr && img_sel) begin
            s_nxt.err = 1'b1;
        end
        if (bus.wr && bus.addr == `CID_OFS_CTRL) begin
            s_nxt.en = bus.wdata[`CID_CTRL_EN];
            s_nxt.force_nak = bus.wdata[`CID_CTRL_NAK];
            s_nxt.force_busy = bus.wdata[`CID_CTRL_BUSY];
            // a refused write in the same cycle keeps the error flag set
            if (bus.wdata[`CID_CTRL_CLR_ERR] && !(bus.wr && img_sel)) begin
                s_nxt.err = 1'b0;
            end
        end

        // register reads, answered in the next cycle
        if (bus.rd) begin
            s_nxt.rd_q = 1'b1;
            s_nxt.rd_mem = img_sel;
            case (bus.addr)
                `CID_OFS_CTRL: begin
                    s_nxt.rd_data = {29'h00000000, s_r.force_busy, s_r.force_nak, s_r.en};
                end
                `CID_OFS_STAT: begin
                    s_nxt.rd_data = stat_word;
                end
                `CID_OFS_LAST: begin
                    s_nxt.rd_data = last_word;
                end
                default: begin
                    s_nxt.rd_data = 32'h00000000;
                end
            endcase
        end

        // reply framing
        case (s_r.st)
            TX_IDLE: begin
                if (disc_req && s_r.en) begin
                    s_nxt.st = TX_HDR;
                    s_nxt.idx = 2'h0;
                    s_nxt.tx_first = 1'b1;
                    if (s_r.force_busy) begin
                        s_nxt.kind = CT_BUSY;
                    end else if (s_r.force_nak || !img_ok) begin
                        s_nxt.kind = CT_NAK;
                    end else begin
                        s_nxt.kind = CT_ACK;
                    end
                    if (s_nxt.kind == CT_ACK) begin
                        s_nxt.tx_last = 1'b0;
                        if (is_cable) begin
                            s_nxt.last_idx = `CID_IDX_CABLE;
                            s_nxt.obj_cnt = `CID_NOBJ_CABLE;
                        end else begin
                            s_nxt.last_idx = `CID_IDX_PRODUCT;
                            s_nxt.obj_cnt = `CID_NOBJ_BASE;
                        end
                    end else begin
                        s_nxt.tx_last = 1'b1;
                        s_nxt.last_idx = 2'h0;
                        s_nxt.obj_cnt = `CID_NOBJ_NAK;
                    end
                    s_nxt.tx_data = {`CID_PD_SID, 1'b1, `CID_VDM_VER, 2'b00, 3'b000,
                                     s_nxt.kind, 1'b0, `CID_CMD_DISC_ID};
                end else if (disc_req && s_r.sent_cnt != 8'hff) begin
                    s_nxt.drop_cnt = (s_r.drop_cnt == 8'hff) ? s_r.drop_cnt :
                                     s_r.drop_cnt + 8'h01;
                end
            end
            TX_HDR: begin
                if (tx_ready) begin
                    s_nxt.tx_first = 1'b0;
                    if (s_r.tx_last) begin
                        s_nxt.st = TX_IDLE;
                        s_nxt.tx_last = 1'b0;
                    end else begin
                        s_nxt.st = TX_FETCH;
                    end
                end
            end
            TX_FETCH: begin
                s_nxt.st = TX_WAIT;
            end
            TX_WAIT: begin
                // header, cert, product and cable words go out as stored
                s_nxt.tx_data = mem_a_q;
                // termination, lanes and plug presence bits pass unchanged
                s_nxt.tx_last = (s_r.idx == s_r.last_idx);
                s_nxt.st = TX_SEND;
            end
            TX_SEND: begin
                if (tx_ready) begin
                    if (s_r.tx_last) begin
                        s_nxt.st = TX_IDLE;
                        s_nxt.tx_last = 1'b0;
                    end else begin
                        s_nxt.idx = s_r.idx + 2'h1;
                        s_nxt.st = TX_FETCH;
                    end
                end
            end
            default: begin
                s_nxt.st = TX_IDLE;
            end
        endcase

        // bookkeeping when a frame completes
        if ((s_r.st == TX_HDR || s_r.st == TX_SEND) && tx_ready && s_r.tx_last) begin
            s_nxt.last_kind = s_r.kind;
            s_nxt.last_cnt = s_r.obj_cnt;
            s_nxt.sent_cnt = (s_r.sent_cnt == 8'hff) ? s_r.sent_cnt :
                             s_r.sent_cnt + 8'h01;
        end
    end

    always_ff @(posedge clk or negedge rst_sync_r) begin
        if (!rst_sync_r) begin
            s_r.st <= TX_IDLE;
            s_r.kind <= CT_REQ;
            s_r.idx <= 2'h0;
            s_r.last_idx <= 2'h0;
            s_r.tx_data <= 32'h00000000;
            s_r.tx_first <= 1'b0;
            s_r.tx_last <= 1'b0;
            s_r.obj_cnt <= 3'h0;
            s_r.legal <= 4'h0;
            s_r.ptype <= `CID_PT_UNDEF;
            s_r.en <= 1'(`CID_CTRL_RST);
            s_r.force_nak <= 1'b0;
            s_r.force_busy <= 1'b0;
            s_r.err <= 1'b0;
            s_r.sent_cnt <= 8'h00;
            s_r.drop_cnt <= 8'h00;
            s_r.last_kind <= CT_REQ;
            s_r.last_cnt <= 3'h0;
            s_r.rd_q <= 1'b0;
            s_r.rd_mem <= 1'b0;
            s_r.rd_data <= 32'h00000000;
        end else begin
            s_r <= s_nxt;
        end
    end

    // outputs
    assign tx.valid = (s_r.st == TX_HDR) || (s_r.st == TX_SEND);
    assign tx.first = s_r.tx_first;
    assign tx.last = s_r.tx_last;
    assign tx.obj_cnt = s_r.obj_cnt;
    assign tx.data = s_r.tx_data;
    assign resp_active = (s_r.st != TX_IDLE);
    // read data stands only in the cycle after the strobe
    assign bus_rdata = !s_r.rd_q ? 32'h00000000 :
                       (s_r.rd_mem ? mem_b_q : s_r.rd_data);
endmodule
`default_nettype wire

/* File: pkg/cable_id_cfg.svh */
// offsets, field positions, reset values and codes of the identity responder
`ifndef CABLE_ID_CFG_SVH
`define CABLE_ID_CFG_SVH

// structured header constants
`define CID_PD_SID 16'hff00
`define CID_VDM_VER 2'b01
`define CID_CMD_DISC_ID 5'h01
`define CID_SVID_HI 31
`define CID_SVID_LO 16
`define CID_VDM_TYPE_BIT 15
`define CID_CT_HI 7
`define CID_CT_LO 6
`define CID_CMD_HI 4
`define CID_CMD_LO 0

// data object counts in the message header and image word indices
`define CID_NOBJ_NAK 3'h1
`define CID_NOBJ_BASE 3'h4
`define CID_NOBJ_CABLE 3'h5
`define CID_IDX_PRODUCT 2'h2
`define CID_IDX_CABLE 2'h3
`define CID_IDX_HDR 2'h0

// register byte offsets
`define CID_OFS_IDH 8'h00
`define CID_OFS_CERT 8'h04
`define CID_OFS_PROD 8'h08
`define CID_OFS_CABLE 8'h0c
`define CID_OFS_CTRL 8'h10
`define CID_OFS_STAT 8'h14
`define CID_OFS_LAST 8'h18

// control register bits and reset value
`define CID_CTRL_EN 0
`define CID_CTRL_NAK 1
`define CID_CTRL_BUSY 2
`define CID_CTRL_CLR_ERR 3
`define CID_CTRL_RST 3'h1

// identity header fields
`define CID_IDH_HOST 31
`define CID_IDH_DEV 30
`define CID_IDH_PT_HI 29
`define CID_IDH_PT_LO 27
`define CID_IDH_MODAL 26
`define CID_IDH_RSV_HI 25
`define CID_IDH_RSV_LO 16
`define CID_PT_UNDEF 3'h0
`define CID_PT_PASSIVE 3'h3
`define CID_PT_ACTIVE 3'h4

// cable object fields
`define CID_CBL_VER_HI 23
`define CID_CBL_VER_LO 21
`define CID_CBL_RSV 20
`define CID_CBL_CONN_HI 19
`define CID_CBL_CONN_LO 18
`define CID_CBL_RECEPT 17
`define CID_CBL_LAT_HI 16
`define CID_CBL_LAT_LO 13
`define CID_CBL_CUR_HI 6
`define CID_CBL_CUR_LO 5
`define CID_CBL_VBUS 4
`define CID_CBL_SS_HI 2
`define CID_CBL_SS_LO 0
`define CID_VER_BAD0 3'h0
`define CID_VER_BAD1 3'h1
`define CID_VER_BAD7 3'h7
`define CID_CONN_TYPEC 2'h2
`define CID_LAT_MIN 4'h1
`define CID_LAT_MAX 4'ha
`define CID_CUR_NONE 2'h0
`define CID_CUR_RSV 2'h3
`define CID_SS_MAX 3'h2

`endif

/* File: pkg/cable_id_pkg.sv */
// types shared by the identity responder files
package cable_id_pkg;

    typedef enum logic [1:0] {
        SOP_PLAIN = 2'h0,
        SOP_PRIME = 2'h1,
        SOP_DPRIME = 2'h2,
        SOP_OTHER = 2'h3
    } sop_kind_t;

    typedef enum logic [1:0] {
        CT_REQ = 2'h0,
        CT_ACK = 2'h1,
        CT_NAK = 2'h2,
        CT_BUSY = 2'h3
    } cmd_type_t;

    typedef enum logic [2:0] {
        TX_IDLE,
        TX_HDR,
        TX_FETCH,
        TX_WAIT,
        TX_SEND
    } tx_st_t;

    typedef struct packed {
        logic valid;
        sop_kind_t sop;
        logic [31:0] hdr;
    } rx_req_t;

    typedef struct packed {
        logic valid;
        logic first;
        logic last;
        logic [2:0] obj_cnt;
        logic [31:0] data;
    } tx_word_t;

    typedef struct packed {
        logic [7:0] addr;
        logic [31:0] wdata;
        logic wr;
        logic rd;
    } bus_req_t;

    typedef struct packed {
        tx_st_t st;
        cmd_type_t kind;
        logic [1:0] idx;
        logic [1:0] last_idx;
        logic [31:0] tx_data;
        logic tx_first;
        logic tx_last;
        logic [2:0] obj_cnt;
        logic [3:0] legal;
        logic [2:0] ptype;
        logic en;
        logic force_nak;
        logic force_busy;
        logic err;
        logic [7:0] sent_cnt;
        logic [7:0] drop_cnt;
        cmd_type_t last_kind;
        logic [2:0] last_cnt;
        logic rd_q;
        logic rd_mem;
        logic [31:0] rd_data;
    } core_t;

endpackage

/* File: design/id_image_mem.sv */
// small image store: one write port, two read ports with registered data
`timescale 1ns/1ns
`default_nettype none
module id_image_mem #(
    parameter int AW = 2,
    parameter int DW = 32
) (
    // clock and reset
    input wire logic clk,
    input wire logic rst_n,
    // write port
    input wire logic wr_en,
    input wire logic [AW-1:0] wr_addr,
    input wire logic [DW-1:0] wr_data,
    // read port a
    input wire logic a_en,
    input wire logic [AW-1:0] a_addr,
    output logic [DW-1:0] a_q,
    // read port b
    input wire logic b_en,
    input wire logic [AW-1:0] b_addr,
    output logic [DW-1:0] b_q
);
    logic [DW-1:0] mem_r [2**AW];

    always_ff @(posedge clk) begin
        if (wr_en) begin
            mem_r[wr_addr] <= wr_data;
        end
    end

    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            a_q <= '0;
            b_q <= '0;
        end else begin
            if (a_en) begin
                a_q <= mem_r[a_addr];
            end
            if (b_en) begin
                b_q <= mem_r[b_addr];
            end
        end
    end
endmodule
`default_nettype wire

/* File: design/vdo_field_check.sv */
// judges one written image word and clears its must-be-zero bits
`timescale 1ns/1ns
`default_nettype none
`include "cable_id_cfg.svh"
module vdo_field_check (
    // word under test
    input wire logic [1:0] idx,
    input wire logic [31:0] word,
    // verdict
    output logic legal,
    output logic [31:0] clean
);
    logic [2:0] pt;
    logic [2:0] ver;
    logic [1:0] conn;
    logic [3:0] lat;
    logic [1:0] cur;
    logic [2:0] ss;

    always_comb begin
        pt = word[`CID_IDH_PT_HI:`CID_IDH_PT_LO];
        ver = word[`CID_CBL_VER_HI:`CID_CBL_VER_LO];
        conn = word[`CID_CBL_CONN_HI:`CID_CBL_CONN_LO];
        lat = word[`CID_CBL_LAT_HI:`CID_CBL_LAT_LO];
        cur = word[`CID_CBL_CUR_HI:`CID_CBL_CUR_LO];
        ss = word[`CID_CBL_SS_HI:`CID_CBL_SS_LO];
        clean = word;
        legal = 1'b1;
        if (idx == `CID_IDX_HDR) begin
            clean[`CID_IDH_RSV_HI:`CID_IDH_RSV_LO] = '0;
            legal = (pt == `CID_PT_UNDEF) || (pt == `CID_PT_PASSIVE) ||
                    (pt == `CID_PT_ACTIVE);
        end else if (idx == `CID_IDX_CABLE) begin
            clean[`CID_CBL_RSV] = 1'b0;
            if (ver == `CID_VER_BAD0 || ver == `CID_VER_BAD1 || ver == `CID_VER_BAD7) begin
                legal = 1'b0;
            end
            if (word[`CID_CBL_RECEPT] && conn >= `CID_CONN_TYPEC) begin
                legal = 1'b0;
            end
            if (lat < `CID_LAT_MIN || lat > `CID_LAT_MAX) begin
                legal = 1'b0;
            end
            if (cur == `CID_CUR_RSV) begin
                legal = 1'b0;
            end
            // a cable that reports a current rating but no vbus path is self-contradictory
            if ((cur == `CID_CUR_NONE) == word[`CID_CBL_VBUS]) begin
                legal = 1'b0;
            end
            if (ss > `CID_SS_MAX) begin
                legal = 1'b0;
            end
        end
    end
endmodule
`default_nettype wire

/* File: sim/cable_id_checker.sv */
// port assertions for the identity responder
`timescale 1ns/1ns
`default_nettype none
module cable_id_checker
    import cable_id_pkg::*;
(
    // clock and reset
    input wire logic clk,
    input wire logic rstn,
    // request and reply
    input wire rx_req_t rx,
    input wire logic tx_ready,
    input wire tx_word_t tx,
    input wire logic resp_active,
    // register port
    input wire bus_req_t bus,
    input wire logic [31:0] bus_rdata
);
    logic [2:0] widx_r;
    logic xfer;
    assign xfer = tx.valid && tx_ready;
    // word index within the frame, header is 0
    always_ff @(posedge clk or negedge rstn) begin
        if (!rstn) begin
            widx_r <= 3'h0;
        end else if (xfer) begin
            widx_r <= tx.last ? 3'h0 : widx_r + 3'h1;
        end
    end
    default clocking cb @(posedge clk); endclocking
    default disable iff (!rstn);
    property p_svid;
        tx.valid && tx.first |-> tx.data[31:15] == {16'hff00, 1'b1} && tx.data[4:0] == 5'h01;
    endproperty
    a_svid: assert property (p_svid) else $error("reply header svid or command wrong");
    property p_nak;
        tx.valid && tx.first && tx.data[7:6] != 2'b01 |-> tx.last && tx.obj_cnt == 3'h1;
    endproperty
    a_nak: assert property (p_nak) else $error("nak or busy reply not one object");
    property p_ack;
        tx.valid && tx.first && tx.data[7:6] == 2'b01 |-> !tx.last && tx.obj_cnt inside {3'h4, 3'h5};
    endproperty
    a_ack: assert property (p_ack) else $error("ack reply count out of range");
    property p_count;
        xfer && tx.last |-> widx_r == tx.obj_cnt - 3'h1;
    endproperty
    a_count: assert property (p_count) else $error("words sent differ from count");
    property p_idh;
        tx.valid && widx_r == 3'h1 |-> tx.data[25:16] == 10'h0 && tx.data[29:27] inside {3'h0, 3'h3, 3'h4};
    endproperty
    a_idh: assert property (p_idh) else $error("id header reserved or type bad");
    property p_cable_sent;
        tx.valid && widx_r == 3'h1 |-> (tx.data[29:27] inside {3'h3, 3'h4}) == (tx.obj_cnt == 3'h5);
    endproperty
    a_cable_sent: assert property (p_cable_sent) else $error("cable object presence wrong");
    property p_cable;
        tx.valid && widx_r == 3'h4 |-> !tx.data[20] && !(tx.data[23:21] inside {3'h0, 3'h1, 3'h7})
            && tx.data[16:13] inside {[4'h1:4'ha]} && tx.data[6:5] != 2'h3 && tx.data[2:0] <= 3'h2;
    endproperty
    a_cable: assert property (p_cable) else $error("cable object field illegal");
    property p_hold;
        tx.valid && !tx_ready |=> tx.valid && $stable(tx.data) && $stable(tx.last);
    endproperty
    a_hold: assert property (p_hold) else $error("reply word changed while stalled");
    property p_sop;
        rx.valid && rx.sop != SOP_PRIME && !resp_active |=> !resp_active;
    endproperty
    a_sop: assert property (p_sop) else $error("non prime request answered");
    property p_rdata;
        !bus.rd |=> bus_rdata == 32'h0;
    endproperty
    a_rdata: assert property (p_rdata) else $error("read data outside read slot");
    c_cable: cover property (tx.valid && tx.first && tx.obj_cnt == 3'h5);
    c_busy: cover property (tx.valid && tx.first && tx.data[7:6] == 2'b11);
    c_stall: cover property (tx.valid && !tx_ready);
endmodule
bind cable_discover_identity_responder cable_id_checker u_port_chk (.clk(clk), .rstn(rstn), .rx(rx),
    .tx_ready(tx_ready), .tx(tx), .resp_active(resp_active), .bus(bus), .bus_rdata(bus_rdata));
`default_nettype wire

/* File: sim/pd_initiator_model.sv */
// port controller model: sends requests, collects reply words
`timescale 1ns/1ns
`default_nettype none
module pd_initiator_model
    import cable_id_pkg::*;
(
    // clock
    input wire logic clk,
    // reply side
    input wire tx_word_t tx,
    input wire logic slow,
    output logic tx_ready,
    // request side
    output rx_req_t rx
);
    logic [36:0] got [$];
    initial begin
        rx = '0;
        tx_ready = 1'b1;
    end
    // slow mode stalls every other cycle
    always @(posedge clk) begin
        tx_ready <= slow ? ~tx_ready : 1'b1;
        if (tx.valid && tx_ready) begin
            got.push_back({tx.first, tx.last, tx.obj_cnt, tx.data});
        end
    end
    function automatic logic [31:0] req_hdr(input logic [4:0] cmd);
        return {16'hff00, 1'b1, 2'b01, 5'h00, CT_REQ, 1'b0, cmd};
    endfunction
    // header lines change after release so a stale value never matches
    task automatic send(input sop_kind_t s, input logic [31:0] h);
        @(posedge clk);
        rx <= '{1'b1, s, h};
        @(posedge clk);
        rx <= '{1'b0, SOP_OTHER, ~h};
    endtask
endmodule
`default_nettype wire

/* File: sim/cable_discover_identity_responder_tb_top.sv */
// bench for the identity responder: image, replies and ignored requests
`timescale 1ns/1ns
`default_nettype none
`define CHK(nm, e, g) begin tests_run++; if ((g) !== (e)) begin fails++; \
    $display("[FAIL] %s expected %h seen %h", nm, e, g); end end
module cable_discover_identity_responder_tb_top;
    import cable_id_pkg::*;
    logic clk;
    logic rstn;
    logic slow;
    logic tx_ready;
    logic resp_active;
    logic [31:0] bus_rdata;
    rx_req_t rx;
    tx_word_t tx;
    bus_req_t bus;
    int fails = 0;
    int tests_run = 0;
    logic [31:0] idh = {2'b11, 3'h3, 1'b1, 10'h3ff, 16'h1234};
    logic [31:0] cbl = {8'ha5, 3'h2, 1'b1, 2'h1, 1'b1, 4'ha, 2'h3, 4'hb, 2'h2, 2'h3, 3'h2};
    // stored forms: id header reserved bits and cable bit 20 read back as zero
    logic [31:0] ok_w [4] = '{32'hdc00_1234, 32'hc0de_1d01, 32'h5678_0102, 32'ha547_5dda};
    always #4 clk = ~clk;
    cable_discover_identity_responder dut (.clk(clk), .rstn(rstn), .rx(rx), .tx_ready(tx_ready),
        .tx(tx), .resp_active(resp_active), .bus(bus), .bus_rdata(bus_rdata));
    pd_initiator_model pm (.clk(clk), .tx(tx), .slow(slow), .tx_ready(tx_ready), .rx(rx));
    task automatic give_verdict();
        $display("checks %0d mismatches %0d", tests_run, fails);
        if (fails == 0 && tests_run > 0) begin
            $display("Test passed");
        end else begin
            $display("Test failed");
        end
        $finish;
    endtask
    task automatic wr(input logic [7:0] a, input logic [31:0] d);
        @(posedge clk);
        bus <= '{a, d, 1'b1, 1'b0};
        @(posedge clk);
        bus <= '0;
    endtask
    task automatic rd(input logic [7:0] a, output logic [31:0] d);
        @(posedge clk);
        bus <= '{a, 32'h0, 1'b0, 1'b1};
        @(posedge clk);
        bus <= '0;
        #1 d = bus_rdata;
    endtask
    function automatic logic [31:0] exp_hdr(input cmd_type_t t);
        return {16'hff00, 1'b1, 2'b01, 5'h00, t, 1'b0, 5'h01};
    endfunction
    task automatic run_req(input sop_kind_t s, input logic [31:0] h);
        int k;
        pm.got.delete();
        pm.send(s, h);
        k = 0;
        repeat (2) @(posedge clk);
        while (resp_active === 1'b1 && k < 300) begin
            @(posedge clk);
            k++;
        end
        if (k == 300) fails++;
        repeat (2) @(posedge clk);
    endtask
    task automatic check_frame(input cmd_type_t t, input int n);
        logic [36:0] e;
        `CHK("reply length", n, pm.got.size())
        for (int i = 0; i < pm.got.size(); i++) begin
            e = {i == 0, i == n - 1, 3'(n), i == 0 ? exp_hdr(t) : ok_w[i - 1]};
            `CHK("reply word", e, pm.got[i])
        end
    endtask
    task automatic t_reset();
        logic [31:0] d;
        rd(8'h10, d);
        `CHK("ctrl reset", 32'h1, d)
        rd(8'h1c, d);
        `CHK("unmapped read", 32'h0, d)
        run_req(SOP_PRIME, pm.req_hdr(5'h01));
        check_frame(CT_NAK, 1);
    endtask
    task automatic t_ack();
        logic [31:0] d;
        wr(8'h00, idh);
        wr(8'h04, ok_w[1]);
        wr(8'h08, ok_w[2]);
        wr(8'h0c, cbl);
        slow <= 1'b1;
        run_req(SOP_PRIME, pm.req_hdr(5'h01));
        check_frame(CT_ACK, 5);
        slow <= 1'b0;
        // last reply register: count 5 in bits 4..2, ack code in bits 1..0
        rd(8'h18, d);
        `CHK("last reply", 32'h15, d)
    endtask
    task automatic t_ignore();
        sop_kind_t s [3] = '{SOP_PLAIN, SOP_DPRIME, SOP_OTHER};
        foreach (s[i]) begin
            run_req(s[i], pm.req_hdr(5'h01));
            `CHK("sop ignored", 0, pm.got.size())
        end
        run_req(SOP_PRIME, pm.req_hdr(5'h02));
        `CHK("command ignored", 0, pm.got.size())
        run_req(SOP_PRIME, pm.req_hdr(5'h01));
        check_frame(CT_ACK, 5);
    endtask
    task automatic t_no_cable();
        ok_w[0] = {2'b01, 3'h0, 1'b0, 10'h0, 16'h1234};
        wr(8'h00, ok_w[0]);
        run_req(SOP_PRIME, pm.req_hdr(5'h01));
        check_frame(CT_ACK, 4);
        ok_w[0] = 32'hdc00_1234;
        wr(8'h00, idh);
    endtask
    task automatic t_forced();
        logic [31:0] c [2] = '{32'h5, 32'h3};
        cmd_type_t k [2] = '{CT_BUSY, CT_NAK};
        foreach (c[i]) begin
            wr(8'h10, c[i]);
            run_req(SOP_PRIME, pm.req_hdr(5'h01));
            check_frame(k[i], 1);
        end
        wr(8'h10, 32'h1);
    endtask
    task automatic t_illegal();
        logic [31:0] m [7] = '{32'he0_0000, 32'h1_e000, 32'h1_e000, 32'h60, 32'h7, 32'he_0000,
                               32'h10};
        logic [31:0] v [7] = '{32'he0_0000, 32'h0, 32'h1_6000, 32'h60, 32'h3, 32'ha_0000, 32'h0};
        foreach (m[i]) begin
            wr(8'h0c, (cbl & ~m[i]) | v[i]);
            run_req(SOP_PRIME, pm.req_hdr(5'h01));
            check_frame(CT_NAK, 1);
            wr(8'h0c, cbl);
            wr(8'h10, 32'h9);
        end
        wr(8'h00, {2'b00, 3'h5, 27'h0});
        run_req(SOP_PRIME, pm.req_hdr(5'h01));
        check_frame(CT_NAK, 1);
    endtask
    // the whole run needs a few hundred cycles
    initial begin
        repeat (20000) @(posedge clk);
        fails++;
        give_verdict();
    end
    initial begin
        clk = 1'b0;
        rstn = 1'b0;
        slow = 1'b0;
        bus = '0;
        repeat (20) @(posedge clk);
        rstn <= 1'b1;
        repeat (3) @(posedge clk);
        t_reset();
        t_ack();
        t_ignore();
        t_no_cable();
        t_forced();
        t_illegal();
        give_verdict();
    end
endmodule
`default_nettype wire
